// file: lps_top.sv
// Behaviour
// - Escape bit in fetched transmit control byte sends stored escape character first.
// - Receiver-active sets once an enabled receiver finds its sync characters.
// - Software resync write restarts hunting if receiver enabled, else stops reception.
// - Resync sets pending flag, blocks line queue output until flag character.
// - Transmit-go clears when both counts zero or memory/parity error sets.
// - Underrun sets when loaded character met data-not-available; software writes zero.
// - Nonexistent-memory error with codes 0000, 0010, 1000 sets flag, clears go.
// - Parity error with code 1000 sets parity flag and clears go.
// - Strip flag drops syncs after sync until first non-sync, then clears.
// - Alternate-tables bit sets at principal zero, clears at alternate zero.
// - Marked receive zero with expect-check treats next one or two characters as check.
// - After last check character: interrupt character, discard byte, interrupt request.
// - Marked receive zero copies next-receive-mode into receiver mode.
// - Marked transmit zero copies next-transmit-mode into transmitter mode.
// - Send-first-check sets on marked zero with send-check or control bit 03.
// - Check bytes follow the exhausting character, second only for 16-bit types; code also sends a second for unused type 01.
// - Second-check pending sets on first check load unless LONGITUDINAL_CHECK; clears on load.
// - Escape-in-flight sets when escape loaded, clears when it has been sent.
// - With 16-bit type, first check defers the result until second check arrives.
// - Expect-second sets when expect-first falls during reception with CRC type.
// - Check type field: 00 LONGITUDINAL_CHECK-8, 10 CRC-16, 11 CRC-CCITT, 01 unused.
`timescale 1ns/1ps
`default_nettype none

`include "lps_params.svh"

module lps_top (
  input wire logic clk_sys,          // 100 MHz system clock
  input wire logic rst_n,            // Async reset
  input wire logic ce,               // Clock enable, freezes all state
  input wire logic hsel,             // AHB select
  input wire logic [31:0] haddr,     // AHB address
  input wire logic [1:0] htrans,     // AHB transfer type
  input wire logic hwrite,           // AHB write
  input wire logic [2:0] hsize,      // AHB size, word only
  input wire logic hready,           // AHB ready
  input wire logic [31:0] hwdata,    // AHB write data
  output logic hreadyout,            // AHB slave ready
  output logic [31:0] hrdata,        // AHB read data
  output logic hresp,                // AHB response
  input wire logic [15:0] rx_enabled, // Receiver enabled per line
  input wire logic tx_fetch,         // Transmit control byte fetched
  input wire logic [3:0] tx_fetch_line, // Its line
  input wire logic [7:0] tx_ctrl,    // Its control byte
  input wire logic tx_zero,          // Transmit count reached zero
  input wire logic [3:0] tx_zero_line, // Its line
  input wire logic tx_zero_alt,      // Alternate count, else principal
  input wire logic tx_zero_marked,   // Count was marked
  input wire logic tx_both_zero,     // Both counts now zero
  input wire logic tx_req,           // Transmitter wants next load
  input wire logic [3:0] tx_req_line, // Its line
  input wire logic tx_loaded,        // Character loaded into transmitter
  input wire logic [3:0] tx_loaded_line, // Its line
  input wire logic tx_dna,           // Transmitter reported no data
  input wire logic tx_sent,          // Character sent
  input wire logic [3:0] tx_sent_line, // Its line
  input wire logic tx_err,           // Transmit memory error
  input wire logic [3:0] tx_err_line, // Its line
  input wire logic tx_err_parity,    // Parity error, else nonexistent
  input wire logic [3:0] tx_err_code, // Transfer status code
  input wire logic rx_sync,          // Sync found
  input wire logic [3:0] rx_sync_line, // Its line
  input wire logic rx_char,          // Character received
  input wire logic [3:0] rx_char_line, // Its line
  input wire logic rx_is_sync,       // Character is a sync
  input wire logic [15:0] rx_acc,    // Accumulated check after it
  input wire logic rx_zero,          // Marked receive count zero
  input wire logic [3:0] rx_zero_line, // Its line
  input wire logic q_out,            // Queue output presented
  input wire logic [3:0] q_out_line, // Its line
  input wire logic q_out_flag,       // It is the resync flag character
  output logic [15:0] tx_go,         // Transmit-go per line
  output logic [15:0] tx_alt,        // Alternate tables per line
  output logic [15:0] rx_hunt,       // Hunting for sync per line
  output logic [15:0] q_block,       // Discard queue output per line
  output logic tx_sel_valid,         // Load answer pulse
  output logic [3:0] tx_sel_line,    // Its line
  output lps_pkg::lps_tx_kind_t tx_sel_kind, // What to load
  output logic [7:0] tx_sel_char,    // Escape character
  output logic rx_ans_valid,         // Receive answer pulse
  output logic [3:0] rx_ans_line,    // Its line
  output logic rx_ans_drop,          // Do not store character
  output logic rx_ans_check,         // Character is a check byte
  output logic chk_done,             // Check result, interrupt request
  output logic [3:0] chk_line,       // Its line
  output logic [15:0] interrupt_character_register,           // Interrupt character value
  output logic [7:0] ctrl_byte       // Control byte to store
);
  lps_pkg::lps_state_t q;
  lps_pkg::lps_state_t n;
  lps_pkg::lps_tx_kind_t pick;
  lps_bus_if bus ();

  lps_ahb u_ahb (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .bus(bus)
  );

  lps_tx_pick u_pick (
    .progress(q.lp[tx_req_line]),
    .kind(pick)
  );

  // Register read; resync command bit reads as zero
  always_comb begin
    logic [3:0] rl;
    rl = bus.addr[8:5];
    bus.rdata = 32'h0000_0000;
    unique case (bus.addr[4:2])
      `LPS_IDX_PP: bus.rdata[15:0] = q.pp[rl] & `LPS_PP_WR_MASK;
      `LPS_IDX_LS: bus.rdata[15:0] = q.ls[rl] & `LPS_LS_RD_MASK;
      `LPS_IDX_LP: bus.rdata[15:0] = q.lp[rl] & `LPS_LP_RD_MASK;
      `LPS_IDX_TXM: bus.rdata[2:0] = q.txm[rl];
      `LPS_IDX_RXM: bus.rdata[2:0] = q.rxm[rl];
      `LPS_IDX_RIC: bus.rdata[15:0] = q.interrupt_character_register;
      default: bus.rdata = 32'h0000_0000;
    endcase
  end

  // Resync-pending clear, then the bus write, then each side's hardware clears before its sets:
  // a flag set in the same cycle as its clear must not be lost
  always_comb begin
    logic [3:0] wl;
    logic [15:0] wd;
    logic wide;
    wl = bus.addr[8:5];
    wd = bus.wdata[15:0];
    wide = 1'b0;
    n = q;
    n.tx_sel_valid = 1'b0;
    n.rx_ans_valid = 1'b0;
    n.chk_done = 1'b0;

    // Flag character at the queue output ends the resync hold
    if (q_out && q_out_flag && q.lp[q_out_line][`LPS_LP_RESYNC_PEND]) begin
      n.lp[q_out_line][`LPS_LP_RESYNC_PEND] = 1'b0;
    end

    if (bus.req && bus.we) begin
      unique case (bus.addr[4:2])
        `LPS_IDX_PP: n.pp[wl] = wd & `LPS_PP_WR_MASK;
        `LPS_IDX_LS: begin
          n.ls[wl] = (q.ls[wl] & ~`LPS_LS_WR_MASK) | (wd & `LPS_LS_WR_MASK);
          n.ls[wl] = n.ls[wl] & (wd | ~`LPS_LS_W0_MASK);
          if (wd[`LPS_LS_RESYNC]) begin
            n.ls[wl][`LPS_LS_ACTIVE] = 1'b0;
            n.hunt[wl] = rx_enabled[wl];
            n.lp[wl][`LPS_LP_RESYNC_PEND] = 1'b1;
          end
        end
        `LPS_IDX_LP: begin
          n.lp[wl] = (q.lp[wl] & ~`LPS_LP_WR_MASK) | (wd & `LPS_LP_WR_MASK);
        end
        `LPS_IDX_TXM: n.txm[wl] = wd[2:0];
        `LPS_IDX_RXM: n.rxm[wl] = wd[2:0];
        default: n.interrupt_character_register = q.interrupt_character_register;
      endcase
    end

    // Transmit side: sent and load clear flags, fetch and count zero set them after
    if (tx_sent && q.lp[tx_sent_line][`LPS_LP_ESC_FLIGHT]) begin
      n.lp[tx_sent_line][`LPS_LP_ESC_FLIGHT] = 1'b0;
    end

    if (tx_req) begin
      n.tx_sel_valid = 1'b1;
      n.tx_sel_line = tx_req_line;
      n.tx_sel_kind = pick;
      n.tx_sel_char = q.pp[tx_req_line][`LPS_PP_ESC_LO +: 8];
      unique case (pick)
        lps_pkg::LPS_TX_ESCAPE: begin
          n.lp[tx_req_line][`LPS_LP_ESC_PEND] = 1'b0;
          n.lp[tx_req_line][`LPS_LP_ESC_FLIGHT] = 1'b1;
        end
        lps_pkg::LPS_TX_CHECK1: begin
          n.lp[tx_req_line][`LPS_LP_SEND1] = 1'b0;
          // LONGITUDINAL_CHECK-8 (type 00) has one check byte only
          n.lp[tx_req_line][`LPS_LP_SEND2] =
            q.pp[tx_req_line][`LPS_PP_TYPE_HI:`LPS_PP_TYPE_LO] != 2'b00;
        end
        lps_pkg::LPS_TX_CHECK2: n.lp[tx_req_line][`LPS_LP_SEND2] = 1'b0;
        lps_pkg::LPS_TX_DATA: n.tx_sel_char = 8'h00;
      endcase
    end

    if (tx_loaded && tx_dna) begin
      n.ls[tx_loaded_line][`LPS_LS_UNDERRUN] = 1'b1;
    end

    if (tx_fetch) begin
      if (tx_ctrl[`LPS_TXCB_ESCAPE]) begin
        n.lp[tx_fetch_line][`LPS_LP_ESC_PEND] = 1'b1;
      end
      if (tx_ctrl[`LPS_TXCB_CHECK]) begin
        n.lp[tx_fetch_line][`LPS_LP_SEND1] = 1'b1;
      end
    end

    if (tx_zero) begin
      n.ls[tx_zero_line][`LPS_LS_ALT] = !tx_zero_alt;
      if (tx_zero_marked) begin
        n.txm[tx_zero_line] = q.lp[tx_zero_line][`LPS_LP_NEXT_LO +: 3];
        if (q.lp[tx_zero_line][`LPS_LP_SEND_CHECK]) begin
          n.lp[tx_zero_line][`LPS_LP_SEND1] = 1'b1;
        end
      end
      if (tx_both_zero) begin
        n.ls[tx_zero_line][`LPS_LS_GO] = 1'b0;
      end
    end

    if (tx_err) begin
      if (tx_err_parity && tx_err_code == `LPS_ST_PAR) begin
        n.ls[tx_err_line][`LPS_LS_PARITY] = 1'b1;
        n.ls[tx_err_line][`LPS_LS_GO] = 1'b0;
      end
      if (!tx_err_parity && (tx_err_code == `LPS_ST_NXM_A || tx_err_code == `LPS_ST_NXM_B
          || tx_err_code == `LPS_ST_PAR)) begin
        n.ls[tx_err_line][`LPS_LS_NXM] = 1'b1;
        n.ls[tx_err_line][`LPS_LS_GO] = 1'b0;
      end
    end

    // Receive side: a character clears strip and expect, sync and count zero set after
    if (rx_char) begin
      n.rx_ans_valid = 1'b1;
      n.rx_ans_line = rx_char_line;
      n.rx_ans_drop = q.ls[rx_char_line][`LPS_LS_STRIP_ON] && rx_is_sync;
      n.rx_ans_check = q.lp[rx_char_line][`LPS_LP_EXP1] || q.lp[rx_char_line][`LPS_LP_EXP2];
      if (!rx_is_sync) begin
        n.ls[rx_char_line][`LPS_LS_STRIP_ON] = 1'b0;
      end
      wide = q.pp[rx_char_line][`LPS_PP_TYPE_HI:`LPS_PP_TYPE_LO] != 2'b00;
      if (q.lp[rx_char_line][`LPS_LP_EXP1]) begin
        n.lp[rx_char_line][`LPS_LP_EXP1] = 1'b0;
        if (wide) begin
          n.lp[rx_char_line][`LPS_LP_EXP2] = 1'b1;
        end else begin
          n.chk_done = 1'b1;
        end
      end else if (q.lp[rx_char_line][`LPS_LP_EXP2]) begin
        n.lp[rx_char_line][`LPS_LP_EXP2] = 1'b0;
        n.chk_done = 1'b1;
      end
      if (n.chk_done) begin
        n.chk_line = rx_char_line;
        n.interrupt_character_register = {`LPS_RIC_CODE, rx_char_line, rx_acc[15:8] | rx_acc[7:0]};
        n.ctrl_byte = `LPS_CB_DISCARD;
      end
    end

    if (rx_sync && rx_enabled[rx_sync_line]) begin
      n.ls[rx_sync_line][`LPS_LS_ACTIVE] = 1'b1;
      n.hunt[rx_sync_line] = 1'b0;
      n.ls[rx_sync_line][`LPS_LS_STRIP_ON] = q.pp[rx_sync_line][`LPS_PP_STRIP];
    end

    if (rx_zero) begin
      n.rxm[rx_zero_line] = q.ls[rx_zero_line][`LPS_LS_NEXT_LO +: 3];
      if (q.ls[rx_zero_line][`LPS_LS_EXPECT]) begin
        n.lp[rx_zero_line][`LPS_LP_EXP1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_line
      assign tx_go[gi] = q.ls[gi][`LPS_LS_GO];
      assign tx_alt[gi] = q.ls[gi][`LPS_LS_ALT];
      assign q_block[gi] = q.lp[gi][`LPS_LP_RESYNC_PEND];
    end
  endgenerate

  assign rx_hunt = q.hunt;
  assign tx_sel_valid = q.tx_sel_valid;
  assign tx_sel_line = q.tx_sel_line;
  assign tx_sel_kind = q.tx_sel_kind;
  assign tx_sel_char = q.tx_sel_char;
  assign rx_ans_valid = q.rx_ans_valid;
  assign rx_ans_line = q.rx_ans_line;
  assign rx_ans_drop = q.rx_ans_drop;
  assign rx_ans_check = q.rx_ans_check;
  assign chk_done = q.chk_done;
  assign chk_line = q.chk_line;
  assign interrupt_character_register = q.interrupt_character_register;
  assign ctrl_byte = q.ctrl_byte;
endmodule

`default_nettype wire

// file: lps_params.svh
`ifndef LPS_PARAMS_SVH
`define LPS_PARAMS_SVH

// Register indices within one line's window (byte address = line*32 + idx*4)
`define LPS_IDX_PP 3'h0
`define LPS_IDX_LS 3'h1
`define LPS_IDX_LP 3'h2
`define LPS_IDX_TXM 3'h3
`define LPS_IDX_RXM 3'h4
`define LPS_IDX_RIC 3'h5

// Writable, write-zero and readable masks
`define LPS_PP_WR_MASK 16'hFF7B
`define LPS_LS_WR_MASK 16'hE484
`define LPS_LS_W0_MASK 16'h0038
`define LPS_LS_RD_MASK 16'hE4FD
`define LPS_LP_WR_MASK 16'hE400
`define LPS_LP_RD_MASK 16'hE4E7

// Protocol parameter fields
`define LPS_PP_STRIP 1
`define LPS_PP_TYPE_LO 3
`define LPS_PP_TYPE_HI 4
`define LPS_PP_ESC_LO 8

// Line state fields
`define LPS_LS_ACTIVE 0
`define LPS_LS_RESYNC 1
`define LPS_LS_GO 2
`define LPS_LS_UNDERRUN 3
`define LPS_LS_NXM 4
`define LPS_LS_PARITY 5
`define LPS_LS_STRIP_ON 6
`define LPS_LS_ALT 7
`define LPS_LS_EXPECT 10
`define LPS_LS_NEXT_LO 13

// Line progress fields
`define LPS_LP_SEND1 0
`define LPS_LP_SEND2 1
`define LPS_LP_ESC_FLIGHT 2
`define LPS_LP_ESC_PEND 3
`define LPS_LP_EXP1 5
`define LPS_LP_EXP2 6
`define LPS_LP_RESYNC_PEND 7
`define LPS_LP_SEND_CHECK 10
`define LPS_LP_NEXT_LO 13

// Control byte bits and codes
`define LPS_TXCB_ESCAPE 1
`define LPS_TXCB_CHECK 3
`define LPS_CB_DISCARD 8'h10
`define LPS_RIC_CODE 4'h5
`define LPS_ST_NXM_A 4'h0
`define LPS_ST_NXM_B 4'h2
`define LPS_ST_PAR 4'h8

`endif

// file: lps_pkg.sv
`default_nettype none

package lps_pkg;

  typedef enum logic [1:0] {
    LPS_TX_DATA,
    LPS_TX_ESCAPE,
    LPS_TX_CHECK1,
    LPS_TX_CHECK2
  } lps_tx_kind_t;

  typedef struct packed {
    logic busy;
    logic write;
    logic hit;
    logic [8:0] addr;
    logic hreadyout;
    logic [31:0] hrdata;
  } lps_ahb_state_t;

  typedef struct packed {
    logic [15:0][15:0] pp;
    logic [15:0][15:0] ls;
    logic [15:0][15:0] lp;
    logic [15:0][2:0] txm;
    logic [15:0][2:0] rxm;
    logic [15:0] hunt;
    logic [15:0] interrupt_character_register;
    logic tx_sel_valid;
    logic [3:0] tx_sel_line;
    lps_tx_kind_t tx_sel_kind;
    logic [7:0] tx_sel_char;
    logic rx_ans_valid;
    logic [3:0] rx_ans_line;
    logic rx_ans_drop;
    logic rx_ans_check;
    logic chk_done;
    logic [3:0] chk_line;
    logic [7:0] ctrl_byte;
  } lps_state_t;

endpackage

`default_nettype wire

// file: lps_bus_if.sv
`timescale 1ns/1ps
`default_nettype none

interface lps_bus_if;
  logic req;
  logic we;
  logic [8:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ahb (output req, output we, output addr, output wdata, input rdata);
  modport regs (input req, input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// file: lps_ahb.sv
`timescale 1ns/1ps
`default_nettype none

module lps_ahb (
  input wire logic clk_sys,       // System clock
  input wire logic rst_n,         // Async reset
  input wire logic ce,            // Clock enable
  input wire logic hsel,          // Slave select
  input wire logic [31:0] haddr,  // Address
  input wire logic [1:0] htrans,  // Transfer type
  input wire logic hwrite,        // Write
  input wire logic hready,        // Bus ready
  input wire logic [31:0] hwdata, // Write data
  output logic hreadyout,         // Slave ready
  output logic [31:0] hrdata,     // Read data
  output logic hresp,             // Always OKAY
  lps_bus_if.ahb bus              // Register side
);
  lps_pkg::lps_ahb_state_t q;
  lps_pkg::lps_ahb_state_t n;

  // One wait state: register file settles before read data is captured
  always_comb begin
    n = q;
    if (q.busy) begin
      n.busy = 1'b0;
      n.hreadyout = 1'b1;
      if (!q.write) begin
        n.hrdata = q.hit ? bus.rdata : 32'h0000_0000;
      end
    end else if (hsel && htrans[1] && hready) begin
      n.busy = 1'b1;
      n.write = hwrite;
      n.hit = (haddr[31:9] == 23'h00_0000);
      n.addr = haddr[8:0];
      n.hreadyout = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{hreadyout: 1'b1, default: '0};
    end else if (ce) begin
      q <= n;
    end
  end

  assign bus.req = q.busy && q.hit;
  assign bus.we = q.write;
  assign bus.addr = q.addr;
  assign bus.wdata = hwdata;
  assign hreadyout = q.hreadyout;
  assign hrdata = q.hrdata;
  assign hresp = 1'b0;
endmodule

`default_nettype wire

// file: lps_tx_pick.sv
`timescale 1ns/1ps
`default_nettype none

`include "lps_params.svh"

module lps_tx_pick (
  input wire logic [15:0] progress,          // Line progress word
  output lps_pkg::lps_tx_kind_t kind         // What to load next
);
  // Check bytes trail the character that closed the block, so they win
  always_comb begin
    if (progress[`LPS_LP_SEND2]) begin
      kind = lps_pkg::LPS_TX_CHECK2;
    end else if (progress[`LPS_LP_SEND1]) begin
      kind = lps_pkg::LPS_TX_CHECK1;
    end else if (progress[`LPS_LP_ESC_PEND]) begin
      kind = lps_pkg::LPS_TX_ESCAPE;
    end else begin
      kind = lps_pkg::LPS_TX_DATA;
    end
  end
endmodule

`default_nettype wire

// file: lps_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module lps_monitor (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic ce, // Run
  input wire logic tx_zero, // Count zero
  input wire logic [3:0] tx_zero_line, // Its line
  input wire logic tx_zero_alt, // Alternate count
  input wire logic tx_both_zero, // Both zero
  input wire logic tx_req, // Load request
  input wire logic [3:0] tx_req_line, // Its line
  input wire logic tx_err, // Memory error
  input wire logic [3:0] tx_err_line, // Its line
  input wire logic tx_err_parity, // Parity kind
  input wire logic [3:0] tx_err_code, // Status code
  input wire logic rx_char, // Character in
  input wire logic [3:0] rx_char_line, // Its line
  input wire logic [15:0] rx_acc, // Accumulated check
  input wire logic q_out, // Queue output
  input wire logic [3:0] q_out_line, // Its line
  input wire logic q_out_flag, // Flag character
  input wire logic [15:0] tx_go, // Go per line
  input wire logic [15:0] tx_alt, // Alternate per line
  input wire logic [15:0] q_block, // Queue blocked
  input wire logic tx_sel_valid, // Load answer
  input wire logic [3:0] tx_sel_line, // Its line
  input wire logic rx_ans_valid, // Receive answer
  input wire logic [3:0] rx_ans_line, // Its line
  input wire logic rx_ans_check, // Check byte
  input wire logic chk_done, // Check result
  input wire logic [3:0] chk_line, // Its line
  input wire logic [15:0] interrupt_character_register, // Interrupt character
  input wire logic [7:0] ctrl_byte // Stored control byte
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_parity_stop: assert property (
    ce && tx_err && tx_err_parity && tx_err_code == 4'h8 |=> !tx_go[$past(tx_err_line)])
    else $error("Go kept after parity error");
  a_nxm_stop: assert property (
    ce && tx_err && !tx_err_parity && tx_err_code == 4'h2 |=> !tx_go[$past(tx_err_line)])
    else $error("Go kept after memory error");
  a_empty_stop: assert property (
    ce && tx_zero && tx_both_zero |=> !tx_go[$past(tx_zero_line)])
    else $error("Go kept with both counts zero");
  a_table_swap: assert property (
    ce && tx_zero |=> tx_alt[$past(tx_zero_line)] == !$past(tx_zero_alt))
    else $error("Table select not switched");
  a_load_answer: assert property (
    ce && tx_req |=> tx_sel_valid && tx_sel_line == $past(tx_req_line))
    else $error("Load request not answered");
  a_rx_answer: assert property (
    ce && rx_char |=> rx_ans_valid && rx_ans_line == $past(rx_char_line))
    else $error("Received character not answered");
  a_check_report: assert property (
    chk_done |-> rx_ans_check && interrupt_character_register[15:8] == {4'h5, chk_line})
    else $error("Check report has wrong code or line");
  a_check_value: assert property (
    chk_done |-> interrupt_character_register[7:0] == ($past(rx_acc[15:8]) | $past(rx_acc[7:0])))
    else $error("Check report value wrong");
  a_discard_byte: assert property (
    chk_done |-> ##1 ctrl_byte == 8'h10)
    else $error("Discard control byte not stored");
  a_flag_release: assert property (
    ce && q_out && q_out_flag |=> !q_block[$past(q_out_line)])
    else $error("Queue still blocked after flag");
endmodule

bind lps_top lps_monitor i_mon (
  .clk_sys, .rst_n, .ce, .tx_zero, .tx_zero_line, .tx_zero_alt, .tx_both_zero,
  .tx_req, .tx_req_line, .tx_err, .tx_err_line, .tx_err_parity, .tx_err_code,
  .rx_char, .rx_char_line, .rx_acc, .q_out, .q_out_line, .q_out_flag, .tx_go,
  .tx_alt, .q_block, .tx_sel_valid, .tx_sel_line, .rx_ans_valid, .rx_ans_line,
  .rx_ans_check, .chk_done, .chk_line, .interrupt_character_register, .ctrl_byte
);

`default_nettype wire

// file: lps_line_model.sv
`timescale 1ns/1ps
`default_nettype none

module lps_line_model (
  input wire logic clk_sys, // Clock
  output logic [9:0] p, // Event pulses
  output logic [3:0] ln, // Event line
  output logic [15:0] x // Event qualifiers
);
  initial begin
    p = 10'h000;
    ln = 4'h0;
    x = 16'h0000;
  end

  // One event for one cycle; line and qualifiers turn to junk after it
  task automatic ev(input int k, input logic [3:0] l, input logic [15:0] q);
    p <= 10'h001 << k;
    ln <= l;
    x <= q;
    @(posedge clk_sys);
    p <= 10'h000;
    ln <= ~l;
    x <= ~q;
    @(posedge clk_sys);
  endtask
endmodule

`default_nettype wire

// file: lps_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [15:0] rx_enabled = 16'h0000;
  logic hreadyout, hresp, tx_sel_valid, rx_ans_drop, rx_ans_check, chk_done;
  logic [31:0] hrdata, rd;
  logic [15:0] tx_go, tx_alt, rx_hunt, q_block, interrupt_character_register, x;
  logic [7:0] tx_sel_char, ctrl_byte;
  logic [3:0] ln;
  logic [9:0] p;
  lps_pkg::lps_tx_kind_t tx_sel_kind;
  int err_count = 0;
  int check_count = 0;
  logic [15:0] err_x [6] = '{16'h0018, 16'h0000, 16'h0002, 16'h0008, 16'h0004, 16'h0000};
  logic [31:0] ls_x [6] = '{32'h0000_0020, 32'h0000_0010, 32'h0000_0010,
    32'h0000_0010, 32'h0000_0080, 32'h0000_0000};
  lps_pkg::lps_tx_kind_t kinds [3] = '{lps_pkg::LPS_TX_CHECK1, lps_pkg::LPS_TX_CHECK2,
    lps_pkg::LPS_TX_DATA};

  always #5 clk_sys = ~clk_sys;

  lps_line_model i_line (.clk_sys(clk_sys), .p(p), .ln(ln), .x(x));

  lps_top i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .rx_enabled(rx_enabled), .tx_fetch(p[0]), .tx_fetch_line(ln), .tx_ctrl(x[7:0]),
    .tx_zero(p[1]), .tx_zero_line(ln), .tx_zero_alt(x[0]), .tx_zero_marked(x[1]),
    .tx_both_zero(x[2]), .tx_req(p[2]), .tx_req_line(ln), .tx_loaded(p[3]),
    .tx_loaded_line(ln), .tx_dna(x[0]), .tx_sent(p[4]), .tx_sent_line(ln),
    .tx_err(p[5]), .tx_err_line(ln), .tx_err_parity(x[4]), .tx_err_code(x[3:0]),
    .rx_sync(p[6]), .rx_sync_line(ln), .rx_char(p[7]), .rx_char_line(ln),
    .rx_is_sync(x[0]), .rx_acc(x), .rx_zero(p[8]), .rx_zero_line(ln), .q_out(p[9]),
    .q_out_line(ln), .q_out_flag(x[0]), .tx_go(tx_go), .tx_alt(tx_alt),
    .rx_hunt(rx_hunt), .q_block(q_block), .tx_sel_valid(tx_sel_valid),
    .tx_sel_line(), .tx_sel_kind(tx_sel_kind), .tx_sel_char(tx_sel_char),
    .rx_ans_valid(), .rx_ans_line(), .rx_ans_drop(rx_ans_drop),
    .rx_ans_check(rx_ans_check), .chk_done(chk_done), .chk_line(), .interrupt_character_register(interrupt_character_register),
    .ctrl_byte(ctrl_byte)
  );

  task automatic complete_run();
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] ad(input int l, input int i);
    return 32'(l * 32 + i * 4);
  endfunction

  // Address phase held until hready, then data phase until hready again
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
    chk(hresp, 1'b0);
  endtask

  initial begin
    #200000;
    err_count++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rc(32'h0000_0200, 32'h0000_0000);
    bus(1'b1, ad(3, 0), 32'h0000_FFFF);
    rc(ad(3, 0), 32'h0000_FF7B);
    rc(ad(4, 0), 32'h0000_0000);
    bus(1'b1, ad(3, 1), 32'h0000_FFFF);
    rc(ad(3, 1), 32'h0000_E484);
    bus(1'b1, ad(2, 0), 32'h0000_5A00);
    i_line.ev(0, 4'h2, 16'h0002);
    i_line.ev(2, 4'h2, 16'h0000);
    chk({tx_sel_valid, tx_sel_kind, tx_sel_char}, {1'b1, lps_pkg::LPS_TX_ESCAPE, 8'h5A});
    i_line.ev(3, 4'h2, 16'h0000);
    rc(ad(2, 2), 32'h0000_0004);
    i_line.ev(4, 4'h2, 16'h0000);
    rc(ad(2, 2), 32'h0000_0000);
    i_line.ev(2, 4'h2, 16'h0000);
    chk(tx_sel_kind, lps_pkg::LPS_TX_DATA);
    i_line.ev(3, 4'h2, 16'h0001);
    rc(ad(2, 1), 32'h0000_0008);
    bus(1'b1, ad(2, 1), 32'h0000_0000);
    rc(ad(2, 1), 32'h0000_0000);
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, ad(1, 1), 32'h0000_0004);
      if (k < 5) begin
        i_line.ev(k < 4 ? 5 : 1, 4'h1, err_x[k]);
      end else begin
        bus(1'b1, ad(1, 1), 32'h0000_0000);
      end
      chk(tx_go[1], 1'b0);
      rc(ad(1, 1), ls_x[k]);
      bus(1'b1, ad(1, 1), 32'h0000_0000);
    end
    bus(1'b1, ad(1, 1), 32'h0000_0080);
    i_line.ev(1, 4'h1, 16'h0001);
    chk(tx_alt[1], 1'b0);
    // Send check with next mode 5, first with the one-byte check type
    bus(1'b1, ad(4, 2), 32'h0000_A400);
    i_line.ev(1, 4'h4, 16'h0002);
    rc(ad(4, 3), 32'h0000_0005);
    rc(ad(4, 2), 32'h0000_A401);
    i_line.ev(2, 4'h4, 16'h0000);
    chk(tx_sel_kind, lps_pkg::LPS_TX_CHECK1);
    rc(ad(4, 2), 32'h0000_A400);
    bus(1'b1, ad(4, 0), 32'h0000_0008);
    i_line.ev(0, 4'h4, 16'h0008);
    for (int k = 0; k < 3; k++) begin
      i_line.ev(2, 4'h4, 16'h0000);
      chk(tx_sel_kind, kinds[k]);
    end
    // Sync, strip, then resync on line 5; line 7 stays disabled
    rx_enabled <= 16'h0020;
    bus(1'b1, ad(5, 0), 32'h0000_0002);
    i_line.ev(6, 4'h7, 16'h0000);
    rc(ad(7, 1), 32'h0000_0000);
    i_line.ev(6, 4'h5, 16'h0000);
    rc(ad(5, 1), 32'h0000_0041);
    i_line.ev(7, 4'h5, 16'h0001);
    chk(rx_ans_drop, 1'b1);
    i_line.ev(7, 4'h5, 16'h0000);
    chk(rx_ans_drop, 1'b0);
    rc(ad(5, 1), 32'h0000_0001);
    bus(1'b1, ad(5, 1), 32'h0000_0002);
    chk({rx_hunt[5], q_block[5]}, 2'b11);
    i_line.ev(9, 4'h5, 16'h0000);
    chk(q_block[5], 1'b1);
    i_line.ev(9, 4'h5, 16'h0001);
    chk(q_block[5], 1'b0);
    i_line.ev(6, 4'h5, 16'h0000);
    rc(ad(5, 1), 32'h0000_0041);
    // Expected check on line 6 for every check type
    bus(1'b1, ad(6, 1), 32'h0000_A400);
    for (int t = 0; t < 4; t++) begin
      bus(1'b1, ad(6, 0), 32'(t * 8));
      i_line.ev(8, 4'h6, 16'h0000);
      i_line.ev(7, 4'h6, 16'h1234);
      chk({rx_ans_check, chk_done}, {1'b1, t == 0});
      if (t != 0) begin
        rc(ad(6, 2), 32'h0000_0040);
        i_line.ev(7, 4'h6, 16'h0F01);
        chk({rx_ans_check, chk_done}, 2'b11);
      end
      chk(interrupt_character_register, {4'h5, 4'h6, t == 0 ? 8'h36 : 8'h0F});
    end
    rc(ad(6, 4), 32'h0000_0005);
    chk(ctrl_byte, 8'h10);
    complete_run();
  end
endmodule

`default_nettype wire
